// ### rtl/diag_regs_pkg.sv
// Package: offsets, field positions, reset values and types for the diagnostic registers
package diag_regs_pkg;
  localparam logic [4:0] OFF_ERR_GAP = 5'h1b;
  localparam logic [4:0] OFF_PKT_LEN = 5'h1c;
  localparam logic [4:0] OFF_CAB_DIAG = 5'h1e;
  localparam logic [4:0] OFF_RST_CTRL = 5'h1f;
  localparam logic [4:0] OFF_INT_STAT = 5'h14;
  localparam logic [4:0] OFF_INT_MASK = 5'h15;
  localparam logic [7:0] GAP_RESET = 8'h7d;
  localparam logic [10:0] LEN_RESET = 11'h5dc;
  localparam logic [7:0] ERR_MAX = 8'hff;
  localparam int ERR_LSB = 8;
  localparam int CAPTURE_BIT = 15;
  localparam int START_BIT = 15;
  localparam int DONE_BIT = 1;
  localparam int FAIL_BIT = 0;
  localparam int QUAL_LSB = 8;
  localparam int SWRST_BIT = 15;
  localparam int RESTART_BIT = 14;
  localparam int RESTART_CYCLES = 4;
  localparam logic [1:0] QUAL_GOOD = 2'h1;
  localparam logic [1:0] QUAL_MID = 2'h2;
  localparam logic [1:0] QUAL_POOR = 2'h3;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_SAT = 2;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } regbus_req_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic [1:0] quality;
  } diag_result_t;
endpackage

// ### rtl/phy_selftest_diag_reset_regs.sv
// Self-test, cable-diagnostic and reset-control register bank of the transceiver
//
// Summary of operation
// - Count checker byte errors in bits 15:8
// - Control write to bit 0/1 freezes count
// - Count mode zero: counter saturates at 0xff
// - Writing bit 15 captures count, clears counter
// - Gap between test packets, reset 125
// - Test packet length field, reset 1500
// - Reserved bits ignore writes, read zero
// - Start bit cleared when done rises
// - Done flag set when measurement finishes
// - Fail flag set when measurement fails
// - Quality codes: 01 good, 10 mid, 11 poor
// - Software reset acts as hardware reset, self-clears
// - Restart resets circuitry, keeps registers, self-clears
`timescale 1ns/1ps
`default_nettype none
module phy_selftest_diag_reset_regs #(
  parameter int ERR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire diag_regs_pkg::regbus_req_t i_bus,
  output logic [15:0] o_rdata,
  input wire logic i_chk_err,
  input wire logic i_count_mode,
  input wire logic i_ctrl_freeze_wr,
  input wire logic i_diag_end,
  input wire diag_regs_pkg::diag_result_t i_diag_res,
  output logic [7:0] o_gap_len,
  output logic [10:0] o_pkt_len,
  output logic o_diag_run,
  output logic o_core_reset,
  output logic o_irq
);
  import diag_regs_pkg::*;

  logic [ERR_W-1:0] err_cnt_r;
  logic [ERR_W-1:0] err_seen_r;
  logic frozen_r;
  logic [7:0] gap_r;
  logic [10:0] len_r;
  logic start_r;
  logic done_r;
  logic fail_r;
  logic [1:0] qual_r;
  logic swrst_r;
  logic [2:0] restart_cnt_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic soft_rst;
  logic wr_err;
  logic wr_len;
  logic wr_diag;
  logic wr_rst;
  logic wr_istat;
  logic wr_imask;
  logic err_sat;
  logic done_rise;
  logic [15:0] rdata_nxt;

  // Software reset is held for one cycle and then acts as the hardware reset
  assign soft_rst = i_reset | swrst_r;
  assign wr_err = i_bus.wr && (i_bus.addr == OFF_ERR_GAP);
  assign wr_len = i_bus.wr && (i_bus.addr == OFF_PKT_LEN);
  assign wr_diag = i_bus.wr && (i_bus.addr == OFF_CAB_DIAG);
  assign wr_rst = i_bus.wr && (i_bus.addr == OFF_RST_CTRL);
  assign wr_istat = i_bus.wr && (i_bus.addr == OFF_INT_STAT);
  assign wr_imask = i_bus.wr && (i_bus.addr == OFF_INT_MASK);
  assign err_sat = !i_count_mode && (err_cnt_r == ERR_W'(ERR_MAX));
  assign done_rise = start_r && i_diag_end;

  // Running error counter; wraps only when count mode is nonzero
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      err_cnt_r <= '0;
    end else if (wr_err && i_bus.wdata[CAPTURE_BIT]) begin
      err_cnt_r <= '0;
    end else if (i_chk_err && !err_sat) begin
      err_cnt_r <= err_cnt_r + ERR_W'(1);
    end
  end

  // Reported count follows the counter until frozen by a control write or a capture
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      frozen_r <= 1'b0;
      err_seen_r <= '0;
    end else if (wr_err && i_bus.wdata[CAPTURE_BIT]) begin
      err_seen_r <= err_cnt_r;
      frozen_r <= 1'b1;
    end else if (i_ctrl_freeze_wr) begin
      frozen_r <= 1'b1;
    end else if (!frozen_r) begin
      err_seen_r <= err_cnt_r;
    end
  end

  // Generator settings; only the documented fields are stored
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      gap_r <= GAP_RESET;
      len_r <= LEN_RESET;
    end else begin
      if (wr_err) begin
        gap_r <= i_bus.wdata[7:0];
      end
      if (wr_len) begin
        len_r <= i_bus.wdata[10:0];
      end
    end
  end

  // Cable diagnostic: start held until completion, results captured then
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      start_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      qual_r <= 2'h0;
    end else if (done_rise) begin
      start_r <= 1'b0;
      done_r <= 1'b1;
      fail_r <= i_diag_res.fail;
      qual_r <= i_diag_res.quality;
    end else if (wr_diag) begin
      start_r <= i_bus.wdata[START_BIT];
      if (i_bus.wdata[START_BIT]) begin
        done_r <= 1'b0;
        fail_r <= 1'b0;
      end
    end
  end

  // Reset control: both bits self-clear; restart spares the registers
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= wr_rst && i_bus.wdata[SWRST_BIT];
    end
  end

  // Restart pulse stretched over a few cycles for the transceiver core
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      restart_cnt_r <= '0;
    end else if (wr_rst && i_bus.wdata[RESTART_BIT]) begin
      restart_cnt_r <= 3'(RESTART_CYCLES);
    end else if (restart_cnt_r != '0) begin
      restart_cnt_r <= restart_cnt_r - 3'h1;
    end
  end

  // Core reset covers hardware, software reset and restart
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= swrst_r || (wr_rst && i_bus.wdata[SWRST_BIT]) ||
                      (wr_rst && i_bus.wdata[RESTART_BIT]) || (restart_cnt_r > 3'h1);
    end
  end

  // Sticky events; a new event wins over a clearing write
  always_ff @(posedge i_mclk) begin
    if (soft_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_istat ? i_bus.wdata[2:0] : 3'h0)) |
                    {err_sat && i_chk_err, done_rise && i_diag_res.fail, done_rise};
      if (wr_imask) begin
        irq_mask_r <= i_bus.wdata[2:0];
      end
    end
  end

  // Read mux; reserved bits and unmapped addresses return zero
  always_comb begin
    rdata_nxt = ZERO16;
    case (i_bus.addr)
      OFF_ERR_GAP: rdata_nxt = {err_seen_r[7:0], gap_r};
      OFF_PKT_LEN: rdata_nxt = {5'h00, len_r};
      OFF_CAB_DIAG: rdata_nxt = {start_r, 5'h00, qual_r, 6'h00, done_r, fail_r};
      OFF_RST_CTRL: rdata_nxt = {swrst_r, 15'h0000}; // restart reads back zero
      OFF_INT_STAT: rdata_nxt = {13'h0000, irq_stat_r};
      OFF_INT_MASK: rdata_nxt = {13'h0000, irq_mask_r};
      default: rdata_nxt = ZERO16;
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= ZERO16;
      o_gap_len <= GAP_RESET;
      o_pkt_len <= LEN_RESET;
      o_diag_run <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_bus.rd ? rdata_nxt : ZERO16;
      o_gap_len <= gap_r;
      o_pkt_len <= len_r;
      o_diag_run <= start_r && !done_rise;
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  sequence s_start_done;
    start_r && i_diag_end;
  endsequence

  a_start_clears: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_start_done |=> !start_r && done_r) else $error("start not cleared at done");
  a_done_holds_fail: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_start_done |=> fail_r == $past(i_diag_res.fail)) else $error("fail flag wrong");
  a_err_saturates: assert property (@(posedge i_mclk) disable iff (soft_rst)
    err_sat && i_chk_err && !wr_err |=> err_cnt_r == ERR_W'(ERR_MAX)) else $error("count wrapped");
  a_capture_clears: assert property (@(posedge i_mclk) disable iff (soft_rst)
    wr_err && i_bus.wdata[CAPTURE_BIT] |=> err_cnt_r == '0 && err_seen_r == $past(err_cnt_r))
    else $error("capture failed");
  a_freeze_holds: assert property (@(posedge i_mclk) disable iff (soft_rst)
    frozen_r && !wr_err |=> $stable(err_seen_r)) else $error("frozen count moved");
  a_gap_write: assert property (@(posedge i_mclk) disable iff (soft_rst)
    wr_err |=> ##1 o_gap_len == $past(i_bus.wdata[7:0], 2)) else $error("gap not stored");
  a_len_write: assert property (@(posedge i_mclk) disable iff (soft_rst)
    wr_len |=> ##1 o_pkt_len == $past(i_bus.wdata[10:0], 2)) else $error("length not stored");
  a_pkt_rsvd: assert property (@(posedge i_mclk) disable iff (soft_rst)
    i_bus.rd && i_bus.addr == OFF_PKT_LEN |=> o_rdata[15:11] == 5'h00)
    else $error("reserved bits set");
  a_swrst_self: assert property (@(posedge i_mclk) disable iff (i_reset)
    wr_rst && i_bus.wdata[SWRST_BIT] |=> swrst_r ##1 !swrst_r && gap_r == GAP_RESET)
    else $error("soft reset wrong");
  a_restart_keeps: assert property (@(posedge i_mclk) disable iff (soft_rst)
    wr_rst && i_bus.wdata[RESTART_BIT] && !i_bus.wdata[SWRST_BIT] |=> o_core_reset && $stable(len_r))
    else $error("restart wrong");

  // Requests that several checks below start from
  sequence s_capture_req;
    wr_err && i_bus.wdata[CAPTURE_BIT];
  endsequence

  sequence s_restart_req;
    wr_rst && i_bus.wdata[RESTART_BIT] && !i_bus.wdata[SWRST_BIT];
  endsequence

  sequence s_start_req;
    wr_diag && i_bus.wdata[START_BIT] && !done_rise;
  endsequence

  // Counter steps by one per error unless saturated or captured
  a_count_step: assert property (@(posedge i_mclk) disable iff (soft_rst)
    i_chk_err && !err_sat && !(wr_err && i_bus.wdata[CAPTURE_BIT])
    |=> err_cnt_r == $past(err_cnt_r) + ERR_W'(1))
    else $error("error count did not step");

  // Without an error or a capture the counter must not drift
  a_count_idle: assert property (@(posedge i_mclk) disable iff (soft_rst)
    !i_chk_err && !(wr_err && i_bus.wdata[CAPTURE_BIT]) |=> $stable(err_cnt_r))
    else $error("error count drifted");

  // Until frozen, the reported count tracks the running one
  a_live_follow: assert property (@(posedge i_mclk) disable iff (soft_rst)
    !frozen_r && !i_ctrl_freeze_wr && !(wr_err && i_bus.wdata[CAPTURE_BIT])
    |=> err_seen_r == $past(err_cnt_r)) else $error("reported count stale");

  // A control-register write locks the reported count
  a_freeze_sets: assert property (@(posedge i_mclk) disable iff (soft_rst)
    i_ctrl_freeze_wr |=> frozen_r)
    else $error("freeze not taken");

  // Capture also locks, so later errors stay invisible to reads
  a_capture_locks: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_capture_req |=> frozen_r)
    else $error("capture did not lock");

  // Run output follows a pending start by one cycle
  a_run_follows: assert property (@(posedge i_mclk) disable iff (soft_rst)
    start_r && !done_rise |=> o_diag_run)
    else $error("run output low while pending");

  // Run output drops in the same cycle as the start bit
  a_run_drops: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_start_done |=> !o_diag_run)
    else $error("run output stuck at done");

  // Quality code is taken with the completion
  a_qual_capture: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_start_done |=> qual_r == $past(i_diag_res.quality))
    else $error("quality not captured");

  // A new start hides the old verdict until the next completion
  a_start_flags: assert property (@(posedge i_mclk) disable iff (soft_rst)
    s_start_req |=> !done_r && !fail_r)
    else $error("old verdict visible after start");

  // Done stays up until software starts a new measurement
  a_done_sticky: assert property (@(posedge i_mclk) disable iff (soft_rst)
    done_r && !(wr_diag && i_bus.wdata[START_BIT]) |=> done_r)
    else $error("done flag dropped");

  // Fail changes only at completion or at a new start
  a_fail_steady: assert property (@(posedge i_mclk) disable iff (soft_rst)
    !done_rise && !(wr_diag && i_bus.wdata[START_BIT]) |=> $stable(fail_r))
    else $error("fail flag moved");

  // Reserved diagnostic bits read as zero
  a_diag_rsvd: assert property (@(posedge i_mclk) disable iff (soft_rst)
    i_bus.rd && i_bus.addr == OFF_CAB_DIAG
    |=> o_rdata[14:10] == 5'h00 && o_rdata[7:2] == 6'h00)
    else $error("diagnostic reserved bits set");

  // Restart bit and reserved reset-control bits read as zero
  a_rst_rsvd: assert property (@(posedge i_mclk) disable iff (soft_rst)
    i_bus.rd && i_bus.addr == OFF_RST_CTRL |=> o_rdata[14:0] == 15'h0000)
    else $error("reset control bits set");

  // Restart loads the full stretch, even during a soft reset
  a_restart_load: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_restart_req |=> restart_cnt_r == 3'(RESTART_CYCLES))
    else $error("restart stretch not loaded");

  // Core reset stays high while the stretch runs
  a_stretch_holds: assert property (@(posedge i_mclk) disable iff (i_reset)
    restart_cnt_r > 3'h1 |=> o_core_reset)
    else $error("core reset dropped early");

  // Interrupt output is the registered OR of the status bits ANDed with the mask
  a_irq_level: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_irq == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt level wrong");

  // Completion event is recorded even against a clearing write
  a_irq_set_wins: assert property (@(posedge i_mclk) disable iff (soft_rst)
    done_rise |=> irq_stat_r[IRQ_DONE])
    else $error("done event lost");

  // Read data are zero outside the cycle after a read
  a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
    !i_bus.rd |=> o_rdata == ZERO16)
    else $error("read data outside read slot");

  // Only the eleven length bits are stored
  a_len_store: assert property (@(posedge i_mclk) disable iff (soft_rst)
    wr_len |=> len_r == $past(i_bus.wdata[10:0]))
    else $error("length register wrong");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the self-test, diagnostic and reset register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import diag_regs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  regbus_req_t bus = '0;
  logic [15:0] o_rdata;
  logic chk_err = 1'b0, cnt_mode = 1'b0, frz_wr = 1'b0, d_end = 1'b0;
  diag_result_t d_res = '0;
  logic [7:0] o_gap_len;
  logic [10:0] o_pkt_len;
  logic o_diag_run, o_core_reset, o_irq;
  int error_cnt = 0, checked = 0, cyc = 0, hi, n;
  logic [7:0] g;
  logic [15:0] l, rv;
  phy_selftest_diag_reset_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_bus(bus),
    .o_rdata(o_rdata), .i_chk_err(chk_err), .i_count_mode(cnt_mode),
    .i_ctrl_freeze_wr(frz_wr), .i_diag_end(d_end), .i_diag_res(d_res),
    .o_gap_len(o_gap_len), .o_pkt_len(o_pkt_len), .o_diag_run(o_diag_run),
    .o_core_reset(o_core_reset), .o_irq(o_irq));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk) bus <= {a, d, 1'b1, 1'b0};
    @(posedge i_mclk) bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_mclk) bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_mclk) bus <= '0;
    #1 d = o_rdata;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask
  task automatic errs(input int k);
    repeat (k) begin
      @(posedge i_mclk) chk_err <= 1'b1;
      @(posedge i_mclk) chk_err <= 1'b0;
    end
  endtask
  // Counts cycles with the core reset high; catches stretch length too
  task automatic count_core(input int span, output int k);
    k = 0;
    repeat (span) begin
      #1 if (o_core_reset === 1'b1) k = k + 1;
      @(posedge i_mclk);
    end
  endtask
  initial begin
    void'($urandom(82701));
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    rdc(OFF_ERR_GAP, {8'h00, GAP_RESET});
    rdc(OFF_PKT_LEN, {5'h00, LEN_RESET});
    cmp({o_gap_len, o_pkt_len[7:0]}, {GAP_RESET, LEN_RESET[7:0]});
    wr(OFF_CAB_DIAG, 16'h7ffc);
    wr(OFF_RST_CTRL, 16'h3fff);
    wr(5'h03, 16'hffff);
    rdc(OFF_CAB_DIAG, ZERO16);
    rdc(OFF_RST_CTRL, ZERO16);
    rdc(5'h03, ZERO16);
    g = 8'($urandom);
    l = 16'($urandom);
    wr(OFF_ERR_GAP, {8'h7f, g});
    wr(OFF_PKT_LEN, l);
    rdc(OFF_ERR_GAP, {8'h00, g});
    rdc(OFF_PKT_LEN, {5'h00, l[10:0]});
    cmp({5'h00, o_pkt_len}, {5'h00, l[10:0]});
    cmp({8'h00, o_gap_len}, {8'h00, g});
    n = 1 + ($urandom % 40);
    errs(n);
    rdc(OFF_ERR_GAP, {8'(n), g});
    errs(300);
    rdc(OFF_ERR_GAP, {ERR_MAX, g});
    rdc(OFF_INT_STAT, 16'h0004);
    wr(OFF_ERR_GAP, {8'h80, g});
    errs(5);
    rdc(OFF_ERR_GAP, {ERR_MAX, g});
    wr(OFF_RST_CTRL, 16'h4000);
    count_core(12, hi);
    cmp(16'(hi), 16'(RESTART_CYCLES));
    rdc(OFF_RST_CTRL, ZERO16);
    rdc(OFF_PKT_LEN, {5'h00, l[10:0]});
    wr(OFF_INT_STAT, 16'h0007);
    wr(OFF_INT_MASK, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CAB_DIAG, 16'h8000);
      @(posedge i_mclk);
      #1 cmp({15'h0, o_diag_run}, 16'h0001);
      rdc(OFF_CAB_DIAG, 16'h8000 | {6'h00, 2'(i), 8'h00});
      @(posedge i_mclk) begin
        d_end <= 1'b1;
        d_res <= {1'b0, i[0], 2'(i + 1)};
      end
      @(posedge i_mclk) d_end <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 cmp({14'h0, o_diag_run, o_irq}, 16'h0001);
      rdc(OFF_CAB_DIAG, {6'h00, 2'(i + 1), 6'h00, 1'b1, i[0]});
      rdc(OFF_INT_STAT, {14'h0, i[0], 1'b1});
      wr(OFF_INT_MASK, ZERO16);
      repeat (2) @(posedge i_mclk);
      #1 cmp({15'h0, o_irq}, ZERO16);
      wr(OFF_INT_MASK, 16'h0003);
      wr(OFF_INT_STAT, 16'h0003);
      repeat (2) @(posedge i_mclk);
      #1 cmp({15'h0, o_irq}, ZERO16);
    end
    wr(OFF_RST_CTRL, 16'h8000);
    count_core(10, hi);
    cmp(16'(hi > 0), 16'h0001);
    rdc(OFF_PKT_LEN, {5'h00, LEN_RESET});
    rdc(OFF_RST_CTRL, ZERO16);
    // Wrap mode, then a control-register freeze
    @(posedge i_mclk) cnt_mode <= 1'b1;
    errs(260);
    rdc(OFF_ERR_GAP, {8'h04, GAP_RESET});
    @(posedge i_mclk) frz_wr <= 1'b1;
    @(posedge i_mclk) frz_wr <= 1'b0;
    errs(3);
    rdc(OFF_ERR_GAP, {8'h04, GAP_RESET});
    tally_and_finish();
  end
endmodule
`default_nettype wire
